//--- src/sflash_cmd_consts.vh
// Opcodes, status bit positions and timing counts for the command logic.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SFLASH_CMD_CONSTS_VH
`define SFLASH_CMD_CONSTS_VH
// Opcodes
`define OP_WRITE_UNLOCK 8'h06
`define OP_WRITE_LOCK 8'h04
`define OP_STATUS_READ 8'h05
`define OP_CONFIG_READ 8'h15
`define OP_STATUS_WRITE 8'h01
`define OP_IDENTITY_READ 8'h9f
`define OP_RESET_ARM 8'h66
`define OP_RESET 8'h99
`define OP_SECURE_EXIT 8'hc1
`define OP_SECURE_ENTER 8'hb1
`define OP_SECURITY_LOCK_WRITE 8'h2f
`define OP_PAGE_PROGRAM 8'h02
`define OP_QUAD_PAGE_PROGRAM 8'h38
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK32_ERASE 8'h52
`define OP_BLOCK64_ERASE 8'hd8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_SUSPEND_A 8'h75
`define OP_SUSPEND_B 8'hb0
// Status bit positions
`define ST_BUSY 0
`define ST_WEL 1
`define ST_PL_LO 2
`define ST_PL_HI 5
`define ST_QE 6
`define ST_SWL 7
// Reset values
`define STATUS_NV_RESET 6'h00
`define CONFIG_RESET 8'h00
// Busy time of a self-timed cycle, in ns, and cycles at 100 MHz
`define BUSY_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define BUSY_CYCLES ((`BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- src/sflash_sync.v
// Two-flop synchroniser for one input level from outside the clock domain.
// Assumes the first flop is read by nothing but the second.
`timescale 1ns/1ps
module sflash_sync (
    input wire mclk_i,
    input wire rst_n_i,
    input wire async_i,
    output wire sync_o
);
    parameter RESET_VAL = 1'b0;
    reg meta_r; // First stage, read only by the second
    reg sync_r; // Safe stage
    // Two stages against metastability
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end
    assign sync_o = sync_r;
endmodule // sflash_sync

//--- src/sflash_cmd_logic.v
// Command decoder and status register of a serial multi-line flash.
// Assumes SPI mode 0 host; pins are sampled by mclk_i, link clock far slower.
`timescale 1ns/1ps
`include "sflash_cmd_consts.vh"
// Operation
// - Secure exit opcode leaves secure area mode
// - Reset only if arm directly precedes it
// - Write unlock opcode framed alone sets latch
// - Write lock opcode framed alone clears latch
// - Latch cleared on completion of listed ops
// - Identity read shifts out 24 ID bits
// - Identity read not decoded while busy
// - Chip select rise returns to standby
// - Status read anytime, byte repeats continuously
// - Config read anytime, byte shifted out
// - Bit 0 busy during program, erase, write
// - Program/erase ignored unless latch set
// - Protected target ignored, latch cleared
// - Protect bits; chip erase only unprotected
// - Quad bit selects data lines or protect
// - Quad mode disables hardware protection, hold
// - Lock bit plus low protect pin: protection
// - Hardware protection rejects status write
// - Config read opcode 15h outputs config byte
// - Status write needs exact byte boundary
module sflash_cmd_logic (
    input wire mclk_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire si_i,
    input wire wp_n_i,
    input wire hold_n_i,
    input wire [7:0] array_cfg_i,
    output reg so_o,
    output wire so_oe_n_o,
    output wire [7:0] device_status_byte_o,
    output wire hold_active_o,
    output wire secure_area_o,
    output wire data_line_2_en_o,
    output wire data_line_3_en_o,
    output wire [7:0] op_start_o,
    output wire op_start_valid_o,
    output wire [23:0] op_addr_o
);
    parameter [7:0] MFR_CODE = 8'h5a; // Arbitrary value
    parameter [15:0] DEV_CODE = 16'h1234; // Arbitrary value
    parameter [15:0] PROTECT_MAP = 16'hfffe; // Levels that protect the top region; level 0 none
    parameter BUSY_CYCLES = `BUSY_CYCLES;

    localparam [2:0] ST_OPCODE = 3'd0; // Collecting opcode
    localparam [2:0] ST_ADDR = 3'd1; // Collecting three address bytes
    localparam [2:0] ST_WDATA = 3'd2; // Collecting status write bytes
    localparam [2:0] ST_OUT = 3'd3; // Shifting data out
    localparam [2:0] ST_IGNORE = 3'd4; // Rest of frame discarded

    wire cs_n_s; // Synced chip select
    wire sclk_s; // Synced link clock
    wire si_s; // Synced serial input
    wire wp_n_s; // Synced protect pin
    wire hold_n_s; // Synced hold pin
    sflash_sync #(.RESET_VAL(1'b1)) u_cs (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .async_i(cs_n_i), .sync_o(cs_n_s));
    sflash_sync #(.RESET_VAL(1'b0)) u_ck (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .async_i(sclk_i), .sync_o(sclk_s));
    sflash_sync #(.RESET_VAL(1'b0)) u_si (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .async_i(si_i), .sync_o(si_s));
    sflash_sync #(.RESET_VAL(1'b1)) u_wp (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .async_i(wp_n_i), .sync_o(wp_n_s));
    sflash_sync #(.RESET_VAL(1'b1)) u_ho (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .async_i(hold_n_i), .sync_o(hold_n_s));

    reg sclk_d_r; // Previous link clock sample
    reg cs_n_d_r; // Previous chip select sample
    reg [2:0] state_r; // Decoder state
    reg [7:0] shift_r; // Incoming byte shifter
    reg [2:0] bitcnt_r; // Bits in current byte
    reg [7:0] opcode_r; // Opcode of this frame
    reg [3:0] bytecnt_r; // Bytes in frame, opcode included
    reg [23:0] addr_r; // Collected address
    reg [7:0] wstat_r; // Status byte of status write
    reg [7:0] wcfg_r; // Config byte of status write
    reg [23:0] out_r; // Outgoing shifter
    reg [4:0] outcnt_r; // Bits shifted out in this frame
    reg [5:0] nv_r; // Protect level, quad, lock bits
    reg [7:0] cfg_r; // Config byte
    reg wel_r; // Write unlock latch
    reg busy_r; // Busy flag
    reg [15:0] busy_cnt_r; // Self-timed cycle counter
    reg armed_r; // Reset armed by previous frame
    reg secure_r; // Secure area mode
    reg [7:0] start_r; // Started operation opcode
    reg start_v_r; // One-cycle start pulse
    reg out_skip_r; // Hold MSB over the first fall
    reg sw_pend_r; // Status write waits for cycle end

    wire sclk_rise = sclk_s & ~sclk_d_r; // Sample edge
    wire sclk_fall = ~sclk_s & sclk_d_r; // Launch edge
    wire frame_end = cs_n_s & ~cs_n_d_r; // Chip select rise
    wire frame_on = ~cs_n_s; // Inside a frame
    wire [7:0] byte_in = {shift_r[6:0], si_s}; // Byte on its last bit
    wire byte_done = sclk_rise & frame_on & (bitcnt_r == 3'd7);
    wire [3:0] plevel = nv_r[3:0]; // Protect level bits
    wire quad_en = nv_r[4];
    wire swl = nv_r[5];
    // protection mode; quad mode overrides it
    wire hw_prot = swl & ~wp_n_s & ~quad_en;
    // configurable level lookup; array_cfg_i marks target as top region
    wire prot_hit = PROTECT_MAP[plevel] & array_cfg_i[0];
    wire [7:0] status_byte = {swl, quad_en, plevel, wel_r, busy_r};
    assign device_status_byte_o = status_byte;

    // Opcode classes
    wire is_prog_erase = (opcode_r == `OP_PAGE_PROGRAM) | (opcode_r == `OP_SECTOR_ERASE) |
        (opcode_r == `OP_BLOCK32_ERASE) | (opcode_r == `OP_BLOCK64_ERASE) |
        (opcode_r == `OP_QUAD_PAGE_PROGRAM);
    wire is_chip_erase = (opcode_r == `OP_CHIP_ERASE_A) | (opcode_r == `OP_CHIP_ERASE_B);
    wire is_quad = opcode_r == `OP_QUAD_PAGE_PROGRAM;
    wire is_suspend = (opcode_r == `OP_SUSPEND_A) | (opcode_r == `OP_SUSPEND_B);

    // Oversampled edge history
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // Frame decoder, registers and self-timed cycles
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_OPCODE;
            shift_r <= 8'h00;
            bitcnt_r <= 3'd0;
            opcode_r <= 8'h00;
            bytecnt_r <= 4'd0;
            addr_r <= 24'h000000;
            wstat_r <= 8'h00;
            wcfg_r <= 8'h00;
            out_r <= 24'h000000;
            outcnt_r <= 5'd0;
            nv_r <= `STATUS_NV_RESET;
            cfg_r <= `CONFIG_RESET;
            wel_r <= 1'b0;
            busy_r <= 1'b0;
            busy_cnt_r <= 16'h0000;
            armed_r <= 1'b0;
            secure_r <= 1'b0;
            start_r <= 8'h00;
            start_v_r <= 1'b0;
            out_skip_r <= 1'b0;
            sw_pend_r <= 1'b0;
        end else begin
            start_v_r <= 1'b0;
            // busy clears when cycle finishes; latch clears then
            if (busy_r) begin
                if (busy_cnt_r == 16'h0001) begin
                    busy_r <= 1'b0;
                    wel_r <= 1'b0;
                    if (sw_pend_r) begin // Later frames may change opcode_r
                        nv_r <= wstat_r[7:2];
                        cfg_r <= wcfg_r;
                        sw_pend_r <= 1'b0;
                    end
                end
                busy_cnt_r <= busy_cnt_r - 16'h0001;
            end
            if (frame_end) begin
                state_r <= ST_OPCODE;
                bitcnt_r <= 3'd0;
                outcnt_r <= 5'd0;
                bytecnt_r <= 4'd0; // An empty frame must not replay the last one
                // arm holds only for the frame right after
                armed_r <= (bytecnt_r == 4'd1) & (bitcnt_r == 3'd0) &
                    (opcode_r == `OP_RESET_ARM);
                if (bitcnt_r == 3'd0 && bytecnt_r == 4'd1 && !busy_r) begin
                    if (opcode_r == `OP_WRITE_UNLOCK) begin
                        wel_r <= 1'b1;
                    end
                    if (opcode_r == `OP_WRITE_LOCK) begin
                        wel_r <= 1'b0;
                    end
                    if (opcode_r == `OP_SECURE_EXIT) begin
                        secure_r <= 1'b0;
                    end
                    if (opcode_r == `OP_SECURE_ENTER) begin
                        secure_r <= 1'b1;
                    end
                    // suspend and security lock write clear latch
                    if (is_suspend || opcode_r == `OP_SECURITY_LOCK_WRITE) begin
                        wel_r <= 1'b0;
                    end
                    if (opcode_r == `OP_RESET && armed_r) begin
                        wel_r <= 1'b0;
                        secure_r <= 1'b0;
                    end
                    // chip erase only when unprotected; needs latch
                    if (is_chip_erase && wel_r) begin
                        if (plevel == 4'h0) begin
                            busy_r <= 1'b1;
                            busy_cnt_r <= BUSY_CYCLES[15:0];
                            start_r <= opcode_r;
                            start_v_r <= 1'b1;
                        end else begin
                            wel_r <= 1'b0;
                        end
                    end
                end
                // exact byte boundary; rejected under protection
                if (opcode_r == `OP_STATUS_WRITE && bitcnt_r == 3'd0 && !busy_r &&
                    (bytecnt_r == 4'd2 || bytecnt_r == 4'd3) && wel_r && !hw_prot) begin
                    busy_r <= 1'b1;
                    busy_cnt_r <= BUSY_CYCLES[15:0];
                    sw_pend_r <= 1'b1;
                    if (bytecnt_r == 4'd2) begin
                        wcfg_r <= cfg_r;
                    end
                end
                // latch required; protected target clears latch
                if (is_prog_erase && bytecnt_r >= 4'd4 && bitcnt_r == 3'd0 && !busy_r &&
                    wel_r && (quad_en || !is_quad)) begin
                    if (prot_hit) begin
                        wel_r <= 1'b0;
                    end else begin
                        busy_r <= 1'b1;
                        busy_cnt_r <= BUSY_CYCLES[15:0];
                        start_r <= opcode_r;
                        start_v_r <= 1'b1;
                    end
                end
            end else if (frame_on && sclk_rise) begin
                shift_r <= byte_in;
                bitcnt_r <= bitcnt_r + 3'd1;
                if (byte_done) begin
                    if (bytecnt_r != 4'hf) begin
                        bytecnt_r <= bytecnt_r + 4'd1;
                    end
                    case (state_r)
                        ST_OPCODE: begin
                            opcode_r <= byte_in;
                            bytecnt_r <= 4'd1;
                            out_skip_r <= 1'b1;
                            if (byte_in == `OP_STATUS_READ) begin
                                state_r <= ST_OUT;
                                out_r <= {status_byte, 16'h0000};
                            end else if (byte_in == `OP_CONFIG_READ) begin
                                // config byte out, even while busy
                                state_r <= ST_OUT;
                                out_r <= {cfg_r, 16'h0000};
                            end else if (byte_in == `OP_IDENTITY_READ && !busy_r) begin
                                // 24 identity bits; not decoded while busy
                                state_r <= ST_OUT;
                                out_r <= {MFR_CODE, DEV_CODE};
                            end else if (byte_in == `OP_STATUS_WRITE) begin
                                state_r <= ST_WDATA;
                            end else if (byte_in == `OP_PAGE_PROGRAM ||
                                byte_in == `OP_QUAD_PAGE_PROGRAM ||
                                byte_in == `OP_SECTOR_ERASE ||
                                byte_in == `OP_BLOCK32_ERASE ||
                                byte_in == `OP_BLOCK64_ERASE) begin
                                state_r <= ST_ADDR;
                            end else begin
                                state_r <= ST_IGNORE;
                            end
                        end
                        ST_ADDR: begin
                            addr_r <= {addr_r[15:0], byte_in};
                            if (bytecnt_r == 4'd3) begin
                                state_r <= ST_IGNORE;
                            end
                        end
                        ST_WDATA: begin
                            if (bytecnt_r == 4'd1 && !busy_r) begin // Pending bytes kept
                                wstat_r <= byte_in;
                            end else if (bytecnt_r == 4'd2 && !busy_r) begin
                                wcfg_r <= byte_in;
                            end
                        end
                        default: begin
                            state_r <= state_r;
                        end
                    endcase
                end
            end else if (frame_on && sclk_fall && state_r == ST_OUT) begin
                // Launch next output bit on falling link clock
                if (out_skip_r) begin
                    out_skip_r <= 1'b0; // Mode 0: this fall ends the opcode, MSB waits
                end else begin
                    outcnt_r <= outcnt_r + 5'd1;
                    out_r <= {out_r[22:0], 1'b0};
                    if (opcode_r == `OP_STATUS_READ && outcnt_r[2:0] == 3'd7) begin
                        out_r <= {status_byte, 16'h0000};
                    end
                end
            end
        end
    end

    // Serial output bit register
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_o <= 1'b0;
        end else begin
            so_o <= out_r[23];
        end
    end

    // Output enabled (low) only while shifting data
    assign so_oe_n_o = ~(frame_on & (state_r == ST_OUT));
    // quad bit turns shared pins to data lines
    assign data_line_2_en_o = quad_en;
    assign data_line_3_en_o = quad_en;
    assign hold_active_o = ~hold_n_s & ~quad_en;
    assign secure_area_o = secure_r;
    assign op_start_o = start_r;
    assign op_start_valid_o = start_v_r;
    assign op_addr_o = addr_r;
endmodule // sflash_cmd_logic

//--- tb/sflash_host_model.sv
// Host SPI model: frames opcodes and data, samples the serial output.
// Assumes mode 0 and an 80 ns link clock made from the 100 MHz bench clock.
`timescale 1ns/1ps
module sflash_host_model (
    input wire mclk_i,
    input wire so_i,
    input wire so_oe_n_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    // Idle: deselected, clock parked low between frames
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    // whole bytes unless the caller wants a torn frame
    // one call is one frame, so arm and reset can go back to back
    task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                        output logic [31:0] rx, output logic oe);
        int i;
        rx = 32'h0;
        oe = 1'b0;
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        for (i = 0; i < ntx + nrx; i++) begin
            // Data moves while the clock is low; unused bits toggle
            si_o <= (i < ntx) ? tx[ntx-1-i] : ~si_o;
            repeat (3) @(posedge mclk_i);
            sclk_o <= 1'b1;
            repeat (5) @(posedge mclk_i);
            // Sampled late in the high phase: the design's pin sync adds delay
            if (i >= ntx) rx = {rx[30:0], so_i};
            if (so_oe_n_i === 1'b0) oe = 1'b1;
            sclk_o <= 1'b0;
        end
        // Released line shows the inverse of its last bit
        si_o <= ~si_o;
        repeat (2) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        repeat (8) @(posedge mclk_i);
    endtask
endmodule // sflash_host_model

//--- tb/sflash_cmd_logic_monitor.sv
// Checker on the command logic's ports; status bits, starts and drive.
// Assumes the bind below attaches it to every instance of the design.
`timescale 1ns/1ps
module sflash_cmd_logic_monitor (
    input wire mclk_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire [7:0] device_status_byte_o,
    input wire so_oe_n_o,
    input wire hold_active_o,
    input wire data_line_2_en_o,
    input wire data_line_3_en_o,
    input wire [7:0] op_start_o,
    input wire op_start_valid_o
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire [7:0] st = device_status_byte_o; // Status shorthand
    busy_end_clear_a: assert property ($fell(st[0]) |-> ##[0:2] !st[1])
        else $error("latch still set after busy cycle");
    start_sets_busy_a: assert property (op_start_valid_o |-> ##[0:2] st[0])
        else $error("start without busy flag");
    start_needs_latch_a: assert property (op_start_valid_o |-> $past(st[1]))
        else $error("start without write latch");
    start_single_a: assert property (op_start_valid_o |=> !op_start_valid_o)
        else $error("start pulse longer than one cycle");
    start_opcode_a: assert property (op_start_valid_o |=> op_start_o inside
        {8'h02, 8'h38, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7})
        else $error("start with a non program opcode");
    chip_erase_free_a: assert property (op_start_valid_o ##1
        (op_start_o == 8'h60 || op_start_o == 8'hc7) |-> st[5:2] == 4'h0)
        else $error("chip erase under protect level");
    quad_lines_a: assert property (data_line_2_en_o == st[6] && data_line_3_en_o == st[6])
        else $error("data line enables differ from quad bit");
    hold_quad_off_a: assert property (hold_active_o |-> !st[6])
        else $error("hold active in quad mode");
    idle_no_drive_a: assert property (cs_n_i [*6] |-> so_oe_n_o)
        else $error("serial out driven while deselected");
    busy_after_cs_a: assert property ($rose(st[0]) |-> cs_n_i)
        else $error("busy began inside a frame");
endmodule // sflash_cmd_logic_monitor
bind sflash_cmd_logic sflash_cmd_logic_monitor u_sflash_cmd_logic_monitor (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .device_status_byte_o(device_status_byte_o), .so_oe_n_o(so_oe_n_o),
    .hold_active_o(hold_active_o), .data_line_2_en_o(data_line_2_en_o),
    .data_line_3_en_o(data_line_3_en_o), .op_start_o(op_start_o),
    .op_start_valid_o(op_start_valid_o)
);

//--- tb/tb.sv
// Self-checking bench: host model on the serial pins, bench on the rest.
// Assumes the monitor binds itself; busy count lengthened to 800 cycles.
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] MFR = 8'h3c; // Arbitrary value
    localparam logic [15:0] DEV = 16'h7e81; // Arbitrary value
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wp_n_i = 1'b1;
    logic hold_n_i = 1'b1;
    logic [7:0] cfg = 8'h00;
    wire cs_n, sclk, si, so, so_oe_n, hold_act, secure, dl2, dl3, start_v;
    wire [7:0] dsb, op;
    wire [23:0] addr;
    logic [31:0] rx;
    logic oe;
    int err_total = 0;
    int checks = 0;
    int starts = 0;
    always #5 mclk_i = ~mclk_i;
    // Start pulses counted so refused commands show as no change
    always @(posedge mclk_i) if (start_v === 1'b1) starts <= starts + 1;
    sflash_cmd_logic #(.MFR_CODE(MFR), .DEV_CODE(DEV), .BUSY_CYCLES(800)) u_sflash_cmd_logic (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
        .wp_n_i(wp_n_i), .hold_n_i(hold_n_i), .array_cfg_i(cfg), .so_o(so),
        .so_oe_n_o(so_oe_n), .device_status_byte_o(dsb), .hold_active_o(hold_act),
        .secure_area_o(secure), .data_line_2_en_o(dl2), .data_line_3_en_o(dl3),
        .op_start_o(op), .op_start_valid_o(start_v), .op_addr_o(addr));
    sflash_host_model u_sflash_host_model (.mclk_i(mclk_i), .so_i(so), .so_oe_n_i(so_oe_n),
        .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic fr(input logic [31:0] tx, input int ntx, input int nrx);
        u_sflash_host_model.xfer(tx, ntx, nrx, rx, oe);
    endtask
    // busy polled under a bound before the next command
    task automatic wait_idle;
        int n;
        n = 0;
        while (dsb[0] !== 1'b0 && n < 1200) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 1200) begin
            err_total++;
            finish_test;
        end
    endtask
    task automatic wstat(input logic [7:0] b);
        fr(32'h06, 8, 0);
        fr({16'h0, 8'h01, b}, 16, 0);
        wait_idle;
    endtask
    task automatic t_basic;
        check("status at reset", dsb, 8'h00);
        fr(32'h06, 8, 0);
        check("latch set", dsb, 8'h02);
        fr(32'h05, 8, 16);
        check("status repeated", rx, 32'h0202);
        fr(32'h15, 8, 8);
        check("config byte", rx, 32'h00);
        fr(32'h04, 8, 0);
        check("latch cleared", dsb, 8'h00);
        fr(32'h9f, 8, 24);
        check("identity", rx, {8'h0, MFR, DEV});
        check("released after id", so_oe_n, 1'b1);
        $display("basic commands done");
    endtask
    task automatic t_status;
        @(posedge mclk_i);
        hold_n_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        check("hold with quad off", hold_act, 1'b1);
        wstat(8'h40);
        check("quad written", dsb, 8'h40);
        check("data lines", {dl3, dl2}, 2'b11);
        check("hold in quad", hold_act, 1'b0);
        wstat(8'h00);
        hold_n_i <= 1'b1;
        fr(32'h06, 8, 0);
        fr(32'h013, 12, 0);
        check("torn write ignored", dsb, 8'h02);
        wstat(8'h80);
        wp_n_i <= 1'b0;
        wstat(8'h00);
        check("locked bits kept", dsb & 8'hfc, 8'h80);
        wp_n_i <= 1'b1;
        wstat(8'h00);
        check("lock released", dsb, 8'h00);
        wstat(8'hc0);
        wp_n_i <= 1'b0;
        wstat(8'h00);
        check("quad lifts protection", dsb, 8'h00);
        wp_n_i <= 1'b1;
        fr(32'h06, 8, 0);
        fr({8'h0, 8'h01, 8'h00, 8'h5a}, 24, 0);
        fr(32'h05, 8, 8);
        check("status during write", rx, 32'h03);
        wait_idle;
        fr(32'h15, 8, 8);
        check("config written", rx, 32'h5a);
        $display("status write done");
    endtask
    task automatic t_prog;
        logic [7:0] ops [5] = '{8'h02, 8'h20, 8'h52, 8'hd8, 8'hc7};
        int n;
        n = starts;
        fr({8'h02, 24'h012345}, 32, 0);
        check("no latch no start", starts, n);
        for (int k = 0; k < 5; k++) begin
            n = starts;
            fr(32'h06, 8, 0);
            fr(k < 4 ? {ops[k], 24'h012345} : {24'h0, ops[k]}, k < 4 ? 32 : 8, 0);
            check("started", starts, n + 1);
            check("start opcode", op, ops[k]);
            check("start address", addr, 24'h012345);
            check("busy", dsb[0], 1'b1);
            if (k == 0) begin
                fr(32'h9f, 8, 24);
                check("no id while busy", oe, 1'b0);
                fr(32'h05, 8, 8);
                check("busy read serially", rx[0], 1'b1);
            end
            wait_idle;
            check("latch after op", dsb[1], 1'b0);
        end
        n = starts;
        fr(32'h06, 8, 0);
        fr({8'h38, 24'h000100}, 32, 0);
        check("quad program refused", starts, n);
        fr(32'h04, 8, 0);
        wstat(8'h04);
        cfg <= 8'h01;
        fr(32'h06, 8, 0);
        fr({8'h20, 24'h000100}, 32, 0);
        check("protected start", starts, n);
        check("protected latch", dsb[1], 1'b0);
        cfg <= 8'h00;
        fr(32'h06, 8, 0);
        fr(32'h60, 8, 0);
        check("chip erase refused", starts, n);
        wstat(8'h00);
        $display("program and erase done");
    endtask
    task automatic t_misc;
        fr(32'h06, 8, 0);
        fr(32'h66, 8, 0);
        fr(32'h05, 8, 8);
        fr(32'h99, 8, 0);
        check("reset after gap", dsb[1], 1'b1);
        fr(32'h66, 8, 0);
        fr(32'h99, 8, 0);
        check("reset clears latch", dsb[1], 1'b0);
        fr(32'h06, 8, 0);
        fr(32'h2f, 8, 0);
        check("lock write clears latch", dsb[1], 1'b0);
        fr(32'h06, 8, 0);
        fr(32'hb0, 8, 0);
        check("suspend clears latch", dsb[1], 1'b0);
        fr(32'hb1, 8, 0);
        check("secure entered", secure, 1'b1);
        fr(32'hc1, 8, 0);
        check("secure left", secure, 1'b0);
        $display("reset and secure done");
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        t_basic;
        t_status;
        t_prog;
        t_misc;
        finish_test;
    end
    // Watchdog for a stalled run
    initial begin
        #900000;
        err_total++;
        finish_test;
    end
endmodule // tb
